/* rtc_regs.svh */
// Offsets, field positions, reset values and counts of the time bytes.
// Assumes it is included by its bare name wherever these are needed.
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
// Byte offsets reached through the serial pointer.
`define RTC_OFS_SUBSEC 4'h0
`define RTC_OFS_SEC 4'h1
`define RTC_OFS_MIN 4'h2
`define RTC_OFS_HOUR 4'h3
`define RTC_OFS_WDAY 4'h4
`define RTC_OFS_COUNT 4'h5
// Field positions.
`define RTC_POS_HALT 7
`define RTC_POS_FAIL_IE 7
`define RTC_POS_RATE_HI 7
`define RTC_POS_RATE_LO 4
// Reset values of the counters and control bits.
`define RTC_RST_SUBSEC 8'h00
`define RTC_RST_SEC 7'h00
`define RTC_RST_MIN 7'h00
`define RTC_RST_HOUR 6'h00
`define RTC_RST_WDAY 3'h1
`define RTC_RST_HALT 1'b0
`define RTC_RST_RATE 4'h0
// Last BCD value of each counter, minutes sharing the seconds one, and the weekday wrap value.
`define RTC_TOP_SUBSEC 8'h99
`define RTC_TOP_SEC 8'h59
`define RTC_TOP_HOUR 8'h23
`define RTC_TOP_WDAY 8'h07
`define RTC_LOW_WDAY 8'h01
// Crystal edges per hundredth, less one (328 - 1).
`define RTC_XTAL_DIV_LAST 9'h147
// Serial slave address; the value is arbitrary.
`define RTC_SLAVE_ADDR 7'h51
`endif

/* rtc_pkg.sv */
// Types shared by the timekeeping block.
// Assumes nothing of its surroundings.
package rtc_pkg;
  // Phase of the serial slave.
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WR, ST_RD}
    i2c_state_t;
endpackage : rtc_pkg

/* rtc_timekeeper.sv */
// Sub-second to weekday counters with their serial slave port.
// Assumes rtc_pkg is compiled first and the SDA wire is open drain.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"

// What this block does
// - Hundredths tick is crystal divided by 328.
// - Clock-byte write clears divider and sub-seconds.
// - Sub-seconds hold BCD tenths and hundredths.
// - Halt bit stops the crystal divider.
// - Seconds and minutes count BCD 0 to 59.
// - Fail interrupt only when its enable set.
// - Hours count BCD 0 to 23.
// - Rate select zero disables square wave.
// - Weekday counts 1 to 7.
// - Access with pointer below 08h freezes the transfer bytes.
// - Written bytes commit at pointer 08h or STOP.
module rtc_timekeeper
(
  // Core clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // Crystal clock and crystal fail detector.
  input wire logic I_XTAL_CLK,
  input wire logic I_XTAL_FAIL,
  // Two-wire serial port; SDA is open drain.
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  // Interrupt and square wave control.
  output logic O_XTAL_FAIL_IRQ,
  output logic [3:0] O_SQUARE_WAVE_RATE_SELECT,
  output logic O_SQUARE_WAVE_OUTPUT_EN
);

  // --------------------------------------------------
  // Declarations
  // --------------------------------------------------
  logic [3:0] meta_r; // First synchroniser stage.
  logic [3:0] sync_r; // Second stage: xtal, fail, scl, sda.
  logic [2:0] last_r; // Previous xtal, scl, sda.
  logic xtal_tick; // Rising crystal edge.
  logic scl_rise; // Rising SCL.
  logic scl_fall; // Falling SCL.
  logic start_det; // START seen.
  logic stop_det; // STOP seen.
  logic [8:0] div_r; // Crystal divider chain.
  logic hund_tick; // One hundredth elapsed.
  logic [7:0] sub_r; // Tenths and hundredths.
  logic [6:0] sec_r; // Seconds.
  logic [6:0] min_r; // Minutes.
  logic [5:0] hour_r; // Hours.
  logic [2:0] wday_r; // Weekday.
  logic halt_r; // Crystal halt.
  logic fail_ie_r; // Crystal fail interrupt enable.
  logic [3:0] rate_r; // Square wave rate select.
  logic rate_en_r; // Square wave output enabled.
  logic [7:0] sub_nxt; // Counter next values.
  logic [7:0] sec_nxt;
  logic [7:0] min_nxt;
  logic [7:0] hour_nxt;
  logic [7:0] wday_nxt;
  rtc_pkg::i2c_state_t state_r; // Serial phase.
  logic [3:0] cnt_r; // Bit count, 8 is the ack bit.
  logic [7:0] shift_r; // Received bits.
  logic rw_r; // Read requested.
  logic [3:0] ptr_r; // Address pointer.
  logic access_r; // Between START and STOP.
  logic [7:0] rx_byte; // Byte completed this cycle.
  logic byte_done; // Eighth data bit taken.
  logic wr_en; // Clock byte written.
  logic freeze; // Transfer bytes held.
  logic dirty_r; // Written bytes wait to commit.
  logic commit; // Copy transfer bytes to counters.
  logic [7:0] xfer_r [0:4]; // Transfer bytes.
  logic [7:0] rd_byte; // Byte at the pointer.
  logic sda_oe_r; // Drives SDA low.
  logic irq_r; // Fail interrupt.

  // Next BCD value, wrapping from top to low.
  function automatic logic [7:0] bcd_next
  (
    input logic [7:0] v,
    input logic [7:0] top,
    input logic [7:0] low
  );
    if (v == top)
      bcd_next = low;
    else if (v[3:0] == 4'h9)
      bcd_next = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_next = v + 8'h01;
  endfunction : bcd_next

  // --------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------
  // Every pin passes two flops; edges look only at the second.
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
    if (I_RST)
    begin
      meta_r <= 4'h3;
      sync_r <= 4'h3;
      last_r <= 3'h3;
    end
    else
    begin
      meta_r <= {I_XTAL_CLK, I_XTAL_FAIL, I_SCL, I_SDA};
      sync_r <= meta_r;
      last_r <= {sync_r[3], sync_r[1], sync_r[0]};
    end

  assign xtal_tick = sync_r[3] & ~last_r[2];
  assign scl_rise = sync_r[1] & ~last_r[1];
  assign scl_fall = ~sync_r[1] & last_r[1];
  // SDA may only move while SCL is high to frame a transfer.
  assign start_det = sync_r[1] & last_r[1] & last_r[0] & ~sync_r[0];
  assign stop_det = sync_r[1] & last_r[1] & ~last_r[0] & sync_r[0];

  // --------------------------------------------------
  // Divider chain
  // --------------------------------------------------
  assign hund_tick = xtal_tick & ~halt_r & (div_r == `RTC_XTAL_DIV_LAST);

  // Counts crystal edges; held while halted and cleared on commit.
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
    if (I_RST)
      div_r <= 9'h000;
    else if (commit)
      div_r <= 9'h000;
    else if (xtal_tick && !halt_r)
      div_r <= hund_tick ? 9'h000 : div_r + 9'h001;

  // --------------------------------------------------
  // Time counters
  // --------------------------------------------------
  always_comb
  begin
    sub_nxt = bcd_next(sub_r, `RTC_TOP_SUBSEC, 8'h00);
    sec_nxt = bcd_next({1'b0, sec_r}, `RTC_TOP_SEC, 8'h00);
    min_nxt = bcd_next({1'b0, min_r}, `RTC_TOP_SEC, 8'h00);
    hour_nxt = bcd_next({2'b00, hour_r}, `RTC_TOP_HOUR, 8'h00);
    wday_nxt = bcd_next({5'h00, wday_r}, `RTC_TOP_WDAY, `RTC_LOW_WDAY);
  end

  // Each wrap carries into the next counter up.
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
    if (I_RST)
    begin
      sub_r <= `RTC_RST_SUBSEC;
      sec_r <= `RTC_RST_SEC;
      min_r <= `RTC_RST_MIN;
      hour_r <= `RTC_RST_HOUR;
      wday_r <= `RTC_RST_WDAY;
    end
    else if (commit)
    begin
      // Sub-seconds restart from zero whatever was written.
      sub_r <= 8'h00;
      sec_r <= xfer_r[1][6:0];
      min_r <= xfer_r[2][6:0];
      hour_r <= xfer_r[3][5:0];
      wday_r <= xfer_r[4][2:0];
    end
    else if (hund_tick)
    begin
      sub_r <= sub_nxt;
      if (sub_r == `RTC_TOP_SUBSEC)
      begin
        sec_r <= sec_nxt[6:0];
        if ({1'b0, sec_r} == `RTC_TOP_SEC)
        begin
          min_r <= min_nxt[6:0];
          if ({1'b0, min_r} == `RTC_TOP_SEC)
          begin
            hour_r <= hour_nxt[5:0];
            if ({2'b00, hour_r} == `RTC_TOP_HOUR)
              wday_r <= wday_nxt[2:0];
          end
        end
      end
    end

  // Control bits that share the time bytes; they also wait for commit.
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
    if (I_RST)
    begin
      halt_r <= `RTC_RST_HALT;
      fail_ie_r <= 1'b0;
      rate_r <= `RTC_RST_RATE;
      rate_en_r <= 1'b0;
    end
    else if (commit)
    begin
      halt_r <= xfer_r[1][`RTC_POS_HALT];
      fail_ie_r <= xfer_r[2][`RTC_POS_FAIL_IE];
      rate_r <= xfer_r[4][`RTC_POS_RATE_HI:`RTC_POS_RATE_LO];
      rate_en_r <= |xfer_r[4][`RTC_POS_RATE_HI:`RTC_POS_RATE_LO];
    end

  // --------------------------------------------------
  // Serial slave
  // --------------------------------------------------
  assign byte_done = scl_rise & (cnt_r == 4'h7);
  assign rx_byte = {shift_r[6:0], sync_r[0]};
  assign wr_en = byte_done & (state_r == rtc_pkg::ST_WR) & ~ptr_r[3];

  // Bits are taken on rising SCL; bit 8 of each byte is the ack.
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
    if (I_RST)
    begin
      state_r <= rtc_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      ptr_r <= 4'h0;
      access_r <= 1'b0;
    end
    else if (start_det)
    begin
      // A repeated START keeps the pointer and pending writes.
      state_r <= rtc_pkg::ST_ADDR;
      cnt_r <= 4'h0;
      access_r <= 1'b1;
    end
    else if (stop_det)
    begin
      state_r <= rtc_pkg::ST_IDLE;
      access_r <= 1'b0;
    end
    else if (scl_rise && state_r != rtc_pkg::ST_IDLE)
    begin
      if (cnt_r != 4'h8)
      begin
        shift_r <= rx_byte;
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == 4'h7)
        begin
          case (state_r)
            rtc_pkg::ST_ADDR:
              // A foreign address drops out without an ack.
              if (rx_byte[7:1] != `RTC_SLAVE_ADDR)
                state_r <= rtc_pkg::ST_IDLE;
              else
                rw_r <= rx_byte[0];
            rtc_pkg::ST_PTR:
              ptr_r <= rx_byte[3:0];
            rtc_pkg::ST_WR:
              ptr_r <= ptr_r + 4'h1;
            default:
              ;
          endcase
        end
      end
      else
      begin
        cnt_r <= 4'h0;
        case (state_r)
          rtc_pkg::ST_ADDR:
            state_r <= rw_r ? rtc_pkg::ST_RD : rtc_pkg::ST_PTR;
          rtc_pkg::ST_PTR:
            state_r <= rtc_pkg::ST_WR;
          rtc_pkg::ST_RD:
          begin
            // The master's nack ends the read.
            ptr_r <= ptr_r + 4'h1;
            if (sync_r[0])
              state_r <= rtc_pkg::ST_IDLE;
          end
          default:
            ;
        endcase
      end
    end

  // SDA changes only while SCL is low, so it never fakes a frame.
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
    if (I_RST)
      sda_oe_r <= 1'b0;
    else if (start_det || stop_det)
      sda_oe_r <= 1'b0;
    else if (scl_fall)
    begin
      case (state_r)
        rtc_pkg::ST_ADDR, rtc_pkg::ST_PTR, rtc_pkg::ST_WR:
          sda_oe_r <= (cnt_r == 4'h8);
        rtc_pkg::ST_RD:
          sda_oe_r <= (cnt_r != 4'h8) & ~rd_byte[~cnt_r[2:0]];
        default:
          sda_oe_r <= 1'b0;
      endcase
    end

  // --------------------------------------------------
  // Transfer bytes
  // --------------------------------------------------
  // Held while a clock address is in use during an access.
  assign freeze = access_r & ~ptr_r[3];
  // Commit once the pointer leaves the clock range or on STOP.
  assign commit = dirty_r & (stop_det | ptr_r[3]);

  // Any clock byte written, even one not held here, restarts time.
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
    if (I_RST)
      dirty_r <= 1'b0;
    else if (wr_en)
      dirty_r <= 1'b1;
    else if (commit)
      dirty_r <= 1'b0;

  // Tracks the counters unless frozen or holding unsent writes.
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
    if (I_RST)
    begin
      for (int i = 0; i < 5; i++)
        xfer_r[i] <= 8'h00;
    end
    else if (wr_en)
    begin
      if (ptr_r < `RTC_OFS_COUNT)
        xfer_r[ptr_r[2:0]] <= rx_byte;
    end
    else if (!freeze && !dirty_r)
    begin
      xfer_r[0] <= sub_r;
      xfer_r[1] <= {halt_r, sec_r};
      xfer_r[2] <= {fail_ie_r, min_r};
      xfer_r[3] <= {2'b00, hour_r};
      xfer_r[4] <= {rate_r, 1'b0, wday_r};
    end

  // Offsets outside the held bytes read as zero.
  always_comb
  begin
    if (ptr_r < `RTC_OFS_COUNT)
      rd_byte = xfer_r[ptr_r[2:0]];
    else
      rd_byte = 8'h00;
  end

  // --------------------------------------------------
  // Outputs
  // --------------------------------------------------
  // The fail detector lives outside; this only gates its level.
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
    if (I_RST)
      irq_r <= 1'b0;
    else
      irq_r <= sync_r[2] & fail_ie_r;

  assign O_SDA_OUT = 1'b0;
  assign O_SDA_OE = sda_oe_r;
  assign O_XTAL_FAIL_IRQ = irq_r;
  assign O_SQUARE_WAVE_RATE_SELECT = rate_r;
  assign O_SQUARE_WAVE_OUTPUT_EN = rate_en_r;

  // --------------------------------------------------
  // Assertions
  // --------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  property p_div_range;
    div_r <= `RTC_XTAL_DIV_LAST;
  endproperty
  a_div_range: assert property (p_div_range)
    else $error("Divider ran past its last count.");

  property p_commit_clear;
    commit |=> (sub_r == 8'h00) && (div_r == 9'h000);
  endproperty
  a_commit_clear: assert property (p_commit_clear)
    else $error("Commit did not clear sub-seconds and divider.");

  property p_sub_bcd;
    (sub_r[7:4] <= 4'h9) && (sub_r[3:0] <= 4'h9);
  endproperty
  a_sub_bcd: assert property (p_sub_bcd)
    else $error("Sub-second digit out of BCD range.");

  property p_halt_hold;
    halt_r && !commit |=> $stable(div_r) && $stable(sub_r);
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("Time moved while halted.");

  property p_sec_range;
    ({1'b0, sec_r} <= `RTC_TOP_SEC) && ({1'b0, min_r} <= `RTC_TOP_SEC);
  endproperty
  a_sec_range: assert property (p_sec_range)
    else $error("Seconds or minutes out of range.");

  property p_irq_gate;
    irq_r |-> $past(fail_ie_r) && $past(sync_r[2]);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Fail interrupt raised without enable.");

  property p_hour_range;
    {2'b00, hour_r} <= `RTC_TOP_HOUR;
  endproperty
  a_hour_range: assert property (p_hour_range)
    else $error("Hours out of range.");

  property p_wday_range;
    (wday_r >= 3'h1) && (wday_r <= 3'h7);
  endproperty
  a_wday_range: assert property (p_wday_range)
    else $error("Weekday out of range.");

  property p_freeze;
    freeze && !wr_en |=> $stable(xfer_r[1]) && $stable(xfer_r[0]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Transfer bytes moved during an access.");

  property p_cascade;
    hund_tick && !commit && (sub_r == `RTC_TOP_SUBSEC)
      |=> (sub_r == 8'h00) && (sec_r != $past(sec_r));
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("Sub-second wrap did not advance seconds.");

  // The hundredths carry is the part of the cascade that short runs reach.
  property p_tenth_carry;
    hund_tick && !commit && (sub_r[3:0] == 4'h9)
      |=> (sub_r[3:0] == 4'h0) && (sub_r[7:4] != $past(sub_r[7:4]));
  endproperty
  a_tenth_carry: assert property (p_tenth_carry)
    else $error("Hundredths wrap did not advance tenths.");

endmodule : rtc_timekeeper
`default_nettype wire

/* i2c_host_model.sv */
// Two-wire bus host that reaches the time bytes of the timekeeper.
// Assumes the device pulls SDA low only while its enable is high.
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// Host model
// --------------------------------------------------------------
module i2c_host_model
(
  // Core clock paces the bus phases.
  input wire logic i_clk,
  // Pull-down enable of the device.
  input wire logic i_dev_oe,
  // Bus wires as both parties see them.
  output logic o_scl,
  output logic o_sda
);
  logic host_low; // High while the host pulls SDA low.

  // Open drain with a pull-up, so a released line reads high.
  assign o_sda = ~(host_low | i_dev_oe);

  // Both wires rest high before the first frame.
  initial
  begin
    o_scl = 1'b1;
    host_low = 1'b0;
  end

  // A quarter bit; each SCL phase lasts two, well over four clocks.
  task q;
    repeat (4) @(negedge i_clk);
  endtask : q

  // One SCL pulse; data moves mid-low so it never moves under SCL high.
  task clk_bit(input logic low, output logic seen);
    q();
    host_low = low;
    q();
    o_scl = 1'b1;
    q();
    seen = o_sda;
    q();
    o_scl = 1'b0;
  endtask : clk_bit

  // Start or repeated start: SDA falls while SCL is high.
  task start;
    q();
    host_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    host_low = 1'b1;
    q();
    o_scl = 1'b0;
  endtask : start

  // Stop: SDA rises while SCL is high.
  task stop;
    q();
    host_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    host_low = 1'b0;
    q();
  endtask : stop

  // Sends a byte MSB first and returns the device acknowledge.
  task send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(~b[i], s);
    clk_bit(1'b0, s);
    ack = ~s;
  endtask : send

  // Takes a byte MSB first, then acknowledges or refuses it.
  task recv(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b0, b[i]);
    clk_bit(~nack, s);
  endtask : recv
endmodule : i2c_host_model
`default_nettype wire

/* tb.sv */
// Self-checking bench for the timekeeping counters.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_regs.svh"
// --------------------------------------------------------------
// Bench
// --------------------------------------------------------------
module tb;
  logic clk = 1'b0; // Core clock.
  logic rst = 1'b1; // Reset, active high.
  logic xtal = 1'b0; // Crystal clock, run faster to keep runs short.
  logic fail = 1'b0; // Crystal fail detector.
  logic dev_oe, scl, sda, sda_out, irq, rate_en;
  logic [3:0] rate;
  logic ack;
  logic [7:0] w [0:4]; // Bytes to write from 00h.
  logic [7:0] r [0:4]; // Bytes read from 00h.
  int failures = 0;
  int checks = 0;
  int cyc = 0;

  rtc_timekeeper i_rtc_timekeeper (.I_CORE_CLK(clk), .I_RST(rst),
    .I_XTAL_CLK(xtal), .I_XTAL_FAIL(fail), .I_SCL(scl), .I_SDA(sda),
    .O_SDA_OUT(sda_out), .O_SDA_OE(dev_oe), .O_XTAL_FAIL_IRQ(irq),
    .O_SQUARE_WAVE_RATE_SELECT(rate), .O_SQUARE_WAVE_OUTPUT_EN(rate_en));
  i2c_host_model i_i2c_host_model (.i_clk(clk), .i_dev_oe(dev_oe),
    .o_scl(scl), .o_sda(sda));

  // Clock of 5 ns period.
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      failures++;
      $display("ERROR cycles expected %0d seen %0d", 79999, cyc);
      close_out();
    end
  end

  // Prints the verdict and ends the run.
  task close_out;
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // Byte comparison; flags are passed zero extended.
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Sends one byte and expects it acknowledged.
  task tx(input logic [7:0] b);
    i_i2c_host_model.send(b, ack);
    chk("ack", 8'h01, {7'h00, ack});
  endtask : tx

  // Writes the five bytes from 00h; the caller sends the stop.
  task wr;
    i_i2c_host_model.start();
    tx({`RTC_SLAVE_ADDR, 1'b0});
    tx(8'h00);
    for (int i = 0; i < 5; i++)
      tx(w[i]);
  endtask : wr

  // Reads the five bytes from 00h, refusing the last.
  task rd;
    i_i2c_host_model.start();
    tx({`RTC_SLAVE_ADDR, 1'b0});
    tx(8'h00);
    i_i2c_host_model.start();
    tx({`RTC_SLAVE_ADDR, 1'b1});
    for (int i = 0; i < 5; i++)
      i_i2c_host_model.recv(i == 4, r[i]);
    i_i2c_host_model.stop();
  endtask : rd

  // Gives n crystal edges, four core clocks each.
  task xt(input int n);
    repeat (n)
    begin
      @(negedge clk);
      xtal = 1'b1;
      repeat (2) @(negedge clk);
      xtal = 1'b0;
      @(negedge clk);
    end
  endtask : xt

  // Reads and checks the sub-second byte.
  task sub(input logic [7:0] e);
    rd();
    chk("subsecond", e, r[0]);
  endtask : sub

  // Loads the write bytes; sub-seconds always zero, unused bits zero.
  task setw(input logic [7:0] a, b, c, d);
    w[0] = 8'h00;
    w[1] = a;
    w[2] = b;
    w[3] = c;
    w[4] = d;
  endtask : setw

  // Main sequence.
  initial
  begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    // Reset values read back and shown at the pins.
    rd();
    for (int i = 0; i < 5; i++)
      chk("reset byte", (i == 4) ? 8'h01 : 8'h00, r[i]);
    chk("sda out", 8'h00, {7'h00, sda_out});
    chk("rate enable", 8'h00, {7'h00, rate_en});
    // Top values of each field but sub-seconds, with fail enable and rate set.
    setw(8'h59, 8'hd9, 8'h23, 8'h57);
    wr();
    i_i2c_host_model.stop();
    rd();
    for (int i = 0; i < 5; i++)
      chk("readback", w[i], r[i]);
    chk("rate", 8'h05, {4'h0, rate});
    chk("rate enable", 8'h01, {7'h00, rate_en});
    chk("irq", 8'h00, {7'h00, irq});
    fail = 1'b1;
    repeat (6) @(negedge clk);
    chk("irq", 8'h01, {7'h00, irq});
    // Hundredths tick at edge 328, then tenths carry.
    xt(327);
    sub(8'h00);
    xt(1);
    sub(8'h01);
    xt(2952);
    sub(8'h10);
    // Edges during an access do not reach the bytes read.
    i_i2c_host_model.start();
    tx({`RTC_SLAVE_ADDR, 1'b0});
    tx(8'h00);
    xt(328);
    i_i2c_host_model.start();
    tx({`RTC_SLAVE_ADDR, 1'b1});
    i_i2c_host_model.recv(1'b1, r[0]);
    i_i2c_host_model.stop();
    chk("frozen", 8'h10, r[0]);
    sub(8'h11);
    // Mid-count write with the halt bit set.
    xt(200);
    setw(8'hb0, 8'hd9, 8'h23, 8'h57);
    wr();
    i_i2c_host_model.stop();
    sub(8'h00);
    chk("seconds", 8'hb0, r[1]);
    xt(400);
    sub(8'h00);
    // Restart, rate off, fail enable off; nothing lands before stop.
    setw(8'h30, 8'h59, 8'h23, 8'h03);
    wr();
    chk("rate held", 8'h05, {4'h0, rate});
    i_i2c_host_model.stop();
    repeat (6) @(negedge clk);
    chk("rate", 8'h00, {4'h0, rate});
    chk("rate enable", 8'h00, {7'h00, rate_en});
    chk("irq", 8'h00, {7'h00, irq});
    xt(327);
    sub(8'h00);
    xt(1);
    sub(8'h01);
    // Pointer reaching 08h commits before any stop arrives.
    setw(8'h30, 8'h59, 8'h23, 8'h93);
    wr();
    for (int i = 0; i < 3; i++)
      tx(8'h00);
    chk("rate at 08h", 8'h09, {4'h0, rate});
    chk("rate enable", 8'h01, {7'h00, rate_en});
    i_i2c_host_model.stop();
    rd();
    chk("seconds at 08h", 8'h30, r[1]);
    close_out();
  end
endmodule : tb
`default_nettype wire
